//--- rss_pkg.sv
// rss_pkg: constants shared by the reset and start-up sequencer
// assumes a 20 MHz system clock and a separate rc tick for the power-up timer
package rss_pkg;

   // system clock rate
   localparam int unsigned CLK_HZ              = 20_000_000;
   // power-up timer nominal time-out
   localparam int unsigned PUT_TIME_MS         = 72;
   // rc oscillator nominal rate feeding the power-up timer
   localparam int unsigned RC_TICK_HZ          = 1_000_000;
   // ticks of the rc oscillator in one power-up time-out
   localparam int unsigned PUT_TICKS           = (PUT_TIME_MS * RC_TICK_HZ) / 1000;
   // oscillator start-up timer length in oscillator_input cycles
   localparam int unsigned STARTUP_CYCLES      = 1024;
   // least brown-out dip length that resets the chip, in microseconds
   localparam int unsigned BROWNOUT_MIN_US     = 100;
   // same time in system clock cycles
   localparam int unsigned BROWNOUT_MIN_CYCLES = BROWNOUT_MIN_US * (CLK_HZ / 1_000_000);
   // oscillator mode codes
   localparam logic [1:0]  OSC_LOW_POWER       = 2'h0;
   localparam logic [1:0]  OSC_CRYSTAL         = 2'h1;
   localparam logic [1:0]  OSC_HIGH_SPEED      = 2'h2;
   localparam logic [1:0]  OSC_RC              = 2'h3;

   // sequencer states, one-hot
   typedef enum logic [3:0] {
      RSS_HOLD  = 4'h1,
      RSS_PUT   = 4'h2,
      RSS_START = 4'h4,
      RSS_RUN   = 4'h8
   } rss_state_type;

endpackage

//--- rss_edge_count.sv
// rss_edge_count: counts rising edges of a synchronous input up to a limit
// assumes the counted input is already synchronous to clock_i
`timescale 1ns/1ps
`default_nettype none
module rss_edge_count #(
   parameter int unsigned LIMIT = 1024,
   parameter int unsigned WIDTH = 24
) (
   input  wire logic clock_i,
   input  wire logic rstn_i,
   input  wire logic clear_i,
   input  wire logic run_i,
   input  wire logic tick_i,
   output logic      done_o
);
   logic [WIDTH-1:0] count_q;
   logic             tick_q;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= tick_i;
      end
   end

   // restart on clear, count edges while running
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         count_q <= '0;
      end else if (clear_i) begin
         count_q <= '0;
      end else if (run_i && tick_i && !tick_q && count_q != WIDTH'(LIMIT)) begin
         count_q <= count_q + WIDTH'(1);
      end
   end

   assign done_o = (count_q == WIDTH'(LIMIT));
endmodule
`default_nettype wire

//--- rss_sequencer.sv
// rss_sequencer: chip-wide reset and start-up sequencing
// assumes supply monitor levels, pins and the rc tick are synchronous to clock_i
//
// How it works
// RULE_01: reset stays asserted while the power-on detector says the supply is low.
// RULE_02: only a rising supply makes a power-on reset; a falling one does not.
// RULE_03: the power-up timer runs 72 ms and is started only by power-on or brown-out.
// RULE_04: reset stays asserted while the power-up timer runs.
// RULE_05: the power-up timer counts ticks of its own rc oscillator input.
// RULE_06: the power-up timer is skipped when its disable bit is one.
// RULE_07: after the power-up timer, 1024 oscillator_input cycles more are waited.
// RULE_08: that wait applies only in crystal modes and only after power-on or sleep wake-up.
// RULE_09: brown-out reset works only when its enable bit is one.
// RULE_10: a brown-out dip shorter than the minimum duration is ignored.
// RULE_11: after a power-on or brown-out reset the sequencer waits for a good supply, then runs the timer.
// RULE_12: a brown-out during the power-up timer restarts it from zero.
// RULE_13: the configuring party should keep the power-up timer on with brown-out on.
// RULE_14: the outside system holds master clear until operating conditions are met.
// RULE_15: master clear, brown-out and watchdog resets are flagged as non-power-up; the code flags them only when they occur in state RSS_RUN.
// RULE_16: reset is released only with no source active and both timers done or skipped.
// RULE_17: both timer counts clear on any new qualifying reset before they expire.
`timescale 1ns/1ps
`default_nettype none
module rss_sequencer #(
   parameter int unsigned PUT_TICKS           = rss_pkg::PUT_TICKS,
   parameter int unsigned STARTUP_CYCLES      = rss_pkg::STARTUP_CYCLES,
   parameter int unsigned BROWNOUT_MIN_CYCLES = rss_pkg::BROWNOUT_MIN_CYCLES
) (
   input  wire logic       clock_i,
   input  wire logic       rstn_i,
   input  wire logic       supply_ok_i,
   input  wire logic       supply_above_brownout_i,
   input  wire logic       master_clear_n_i,
   input  wire logic       watchdog_reset_i,
   input  wire logic       sleep_wake_i,
   input  wire logic       rc_tick_i,
   input  wire logic       oscillator_input_i,
   input  wire logic [1:0] osc_mode_i,
   input  wire logic       power_up_timer_disable_i,
   input  wire logic       brownout_detect_enable_i,
   output logic            chip_reset_o,
   output logic            power_on_flag_o,
   output logic            non_power_up_reset_o
);
   rss_pkg::rss_state_type state_q;
   logic        supply_ok_q;
   logic        por_event;
   logic        brownout_event;
   logic        por_pending_q;
   logic        startup_wanted_q;
   logic        power_up_pending;
   logic        startup_pending;
   logic [23:0] dip_count_q;
   logic        put_clear;
   logic        startup_clear;
   logic        put_done;
   logic        startup_done;
   logic        crystal_mode;
   logic        ext_reset;

   ////////////////////////////////////////////////////////////////////
   // reset sources

   // RULE_02 rising supply only
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         supply_ok_q <= 1'b0;
      end else begin
         supply_ok_q <= supply_ok_i;
      end
   end
   assign por_event = supply_ok_i && !supply_ok_q;

   // RULE_09 RULE_10 filtered brown-out
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dip_count_q <= '0;
      end else if (!brownout_detect_enable_i || supply_above_brownout_i) begin
         dip_count_q <= '0;
      end else if (dip_count_q != 24'(BROWNOUT_MIN_CYCLES)) begin
         dip_count_q <= dip_count_q + 24'h1;
      end
   end
   assign brownout_event = brownout_detect_enable_i && !supply_above_brownout_i
                           && dip_count_q == 24'(BROWNOUT_MIN_CYCLES);

   assign ext_reset    = !master_clear_n_i || watchdog_reset_i;
   assign crystal_mode = osc_mode_i != rss_pkg::OSC_RC;

   // a power-on seen in hold arms the timers in that same cycle
   assign power_up_pending = por_pending_q || por_event;
   assign startup_pending  = startup_wanted_q || por_event;

   ////////////////////////////////////////////////////////////////////
   // sequencer

   // RULE_01 RULE_06 RULE_11 RULE_16 state flow
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= rss_pkg::RSS_HOLD;
      end else if (!supply_ok_i || brownout_event) begin
         state_q <= rss_pkg::RSS_HOLD;
      end else begin
         case (state_q)
            rss_pkg::RSS_HOLD: begin
               if (ext_reset) begin
                  state_q <= rss_pkg::RSS_HOLD;
               end else if (!power_up_pending) begin
                  // plain external reset skips both timers
                  state_q <= rss_pkg::RSS_RUN;
               end else if (!power_up_timer_disable_i) begin
                  state_q <= rss_pkg::RSS_PUT;
               end else if (startup_pending && crystal_mode) begin
                  state_q <= rss_pkg::RSS_START;
               end else begin
                  state_q <= rss_pkg::RSS_RUN;
               end
            end
            rss_pkg::RSS_PUT: begin
               if (ext_reset) begin
                  state_q <= rss_pkg::RSS_HOLD;
               end else if (put_done) begin
                  state_q <= (startup_wanted_q && crystal_mode) ? rss_pkg::RSS_START
                                                                : rss_pkg::RSS_RUN;
               end
            end
            rss_pkg::RSS_START: begin
               if (ext_reset) begin
                  state_q <= rss_pkg::RSS_HOLD;
               end else if (startup_done) begin
                  state_q <= rss_pkg::RSS_RUN;
               end
            end
            rss_pkg::RSS_RUN: begin
               if (ext_reset) begin
                  state_q <= rss_pkg::RSS_HOLD;
               end else if (sleep_wake_i && crystal_mode) begin
                  state_q <= rss_pkg::RSS_START;
               end
            end
            default: begin
               state_q <= rss_pkg::RSS_HOLD;
            end
         endcase
      end
   end

   // RULE_03 RULE_08 which sources arm the timers
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         por_pending_q    <= 1'b1;
         startup_wanted_q <= 1'b1;
      end else if (por_event) begin
         por_pending_q    <= 1'b1;
         startup_wanted_q <= 1'b1;
      end else if (brownout_event) begin
         por_pending_q    <= 1'b1;
         startup_wanted_q <= 1'b0;
      end else if (state_q == rss_pkg::RSS_RUN) begin
         por_pending_q    <= 1'b0;
         startup_wanted_q <= 1'b0;
      end
   end

   // RULE_15 reset class
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         power_on_flag_o      <= 1'b1;
         non_power_up_reset_o <= 1'b0;
      end else if (por_event) begin
         power_on_flag_o      <= 1'b1;
         non_power_up_reset_o <= 1'b0;
      end else if (state_q == rss_pkg::RSS_RUN && (ext_reset || brownout_event)) begin
         power_on_flag_o      <= 1'b0;
         non_power_up_reset_o <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // timers

   // RULE_12 RULE_17 restart counts
   assign put_clear = state_q != rss_pkg::RSS_PUT;
   assign startup_clear = state_q != rss_pkg::RSS_START;

   // RULE_05 rc tick count
   rss_edge_count #(
      .LIMIT (PUT_TICKS),
      .WIDTH (24)
   ) u_put (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .clear_i (put_clear),
      .run_i   (1'b1),
      .tick_i  (rc_tick_i),
      .done_o  (put_done)
   );

   // RULE_07 oscillator cycles
   rss_edge_count #(
      .LIMIT (STARTUP_CYCLES),
      .WIDTH (24)
   ) u_startup (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .clear_i (startup_clear),
      .run_i   (1'b1),
      .tick_i  (oscillator_input_i),
      .done_o  (startup_done)
   );

   // RULE_04 RULE_16 reset output
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         chip_reset_o <= 1'b1;
      end else begin
         chip_reset_o <= !(state_q == rss_pkg::RSS_RUN && supply_ok_i && !ext_reset
                           && !brownout_event);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   property p_hold_low_supply;
      @(posedge clock_i) disable iff (!rstn_i)
      !supply_ok_i |=> chip_reset_o;
   endproperty
   a_hold_low_supply: assert property (p_hold_low_supply) // RULE_01
      else $error("reset released with supply low");

   property p_put_holds;
      @(posedge clock_i) disable iff (!rstn_i)
      state_q == rss_pkg::RSS_PUT |=> chip_reset_o;
   endproperty
   a_put_holds: assert property (p_put_holds) // RULE_04
      else $error("reset released while power-up timer runs");

   property p_put_skip;
      @(posedge clock_i) disable iff (!rstn_i)
      power_up_timer_disable_i |-> state_q != rss_pkg::RSS_PUT || $past(state_q) == state_q;
   endproperty
   a_put_skip: assert property (p_put_skip) // RULE_06
      else $error("power-up timer entered while disabled");

   property p_startup_mode;
      @(posedge clock_i) disable iff (!rstn_i)
      $rose(state_q == rss_pkg::RSS_START) |-> $past(crystal_mode);
   endproperty
   a_startup_mode: assert property (p_startup_mode) // RULE_08
      else $error("start-up wait outside crystal mode");

   property p_brownout_off;
      @(posedge clock_i) disable iff (!rstn_i)
      !brownout_detect_enable_i |-> !brownout_event;
   endproperty
   a_brownout_off: assert property (p_brownout_off) // RULE_09
      else $error("brown-out while disabled");

   property p_short_dip;
      @(posedge clock_i) disable iff (!rstn_i)
      $rose(!supply_above_brownout_i) ##1 supply_above_brownout_i |-> !brownout_event;
   endproperty
   a_short_dip: assert property (p_short_dip) // RULE_10
      else $error("short dip caused brown-out");

   property p_put_restart;
      @(posedge clock_i) disable iff (!rstn_i)
      state_q == rss_pkg::RSS_PUT && brownout_event
      |=> state_q == rss_pkg::RSS_HOLD ##1 !put_done;
   endproperty
   a_put_restart: assert property (p_put_restart) // RULE_12
      else $error("power-up timer not restarted");

   property p_release;
      @(posedge clock_i) disable iff (!rstn_i)
      $fell(chip_reset_o) |-> $past(state_q == rss_pkg::RSS_RUN && !ext_reset);
   endproperty
   a_release: assert property (p_release) // RULE_16
      else $error("reset released early");

   c_power_up: cover property (@(posedge clock_i) disable iff (!rstn_i)
      state_q == rss_pkg::RSS_PUT ##1 state_q == rss_pkg::RSS_START);
   c_brownout: cover property (@(posedge clock_i) disable iff (!rstn_i) brownout_event);
   c_release: cover property (@(posedge clock_i) disable iff (!rstn_i) $fell(chip_reset_o));
endmodule
`default_nettype wire

//--- rss_partner.sv
// rss_partner: free-running rc oscillator and crystal seen by the sequencer
// assumes the bench clock; both outputs change on its falling edge
`timescale 1ns/1ps
`default_nettype none
module rss_partner #(
   parameter int unsigned RC_HALF  = 5,
   parameter int unsigned OSC_HALF = 2
) (
   input  wire logic clock_i,
   output var logic  rc_tick_o,
   output var logic  osc_o
);
   int unsigned rc_cnt  = 0;
   int unsigned osc_cnt = 0;
   initial rc_tick_o = 1'b0;
   initial osc_o = 1'b0;
   always @(negedge clock_i) begin
      rc_cnt = rc_cnt + 1;
      if (rc_cnt == RC_HALF) begin
         rc_cnt = 0;
         rc_tick_o <= ~rc_tick_o;
      end
   end
   always @(negedge clock_i) begin
      osc_cnt = osc_cnt + 1;
      if (osc_cnt == OSC_HALF) begin
         osc_cnt = 0;
         osc_o <= ~osc_o;
      end
   end
endmodule
`default_nettype wire

//--- rss_sequencer_bench.sv
// rss_sequencer_bench: self-checking bench for the reset sequencer
// assumes small timer parameters and the free-running partner clocks
`timescale 1ns/1ps
`default_nettype none
module rss_sequencer_bench;
   localparam int PT = 8, OC = 4, BM = 3, RCP = 10, OSP = 4;
   logic clock_i = 1'b0, rstn_i = 1'b0, sok = 1'b0, sab = 1'b1, clear_n = 1'b1;
   logic wdt = 1'b0, wake = 1'b0, put_off = 1'b0, bo_en = 1'b0;
   logic [1:0] mode = rss_pkg::OSC_CRYSTAL;
   logic rc, osc, chip_reset_o, power_on_flag_o, non_power_up_reset_o;
   int errors = 0, checks_done = 0, n;
   rss_partner #(.RC_HALF(RCP/2), .OSC_HALF(OSP/2)) rss_partner_i (
      .clock_i(clock_i), .rc_tick_o(rc), .osc_o(osc));
   rss_sequencer #(
      .PUT_TICKS(PT), .STARTUP_CYCLES(OC), .BROWNOUT_MIN_CYCLES(BM)
   ) rss_sequencer_i (
      .clock_i(clock_i), .rstn_i(rstn_i), .supply_ok_i(sok), .supply_above_brownout_i(sab),
      .master_clear_n_i(clear_n), .watchdog_reset_i(wdt), .sleep_wake_i(wake),
      .rc_tick_i(rc), .oscillator_input_i(osc), .osc_mode_i(mode),
      .power_up_timer_disable_i(put_off), .brownout_detect_enable_i(bo_en),
      .chip_reset_o(chip_reset_o), .power_on_flag_o(power_on_flag_o),
      .non_power_up_reset_o(non_power_up_reset_o));
   initial forever #25 clock_i = ~clock_i;
   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clock_i);
   endtask
   // cycles until reset falls, bounded
   task automatic wait_rel(output int c);
      c = 0;
      while (chip_reset_o !== 1'b0 && c < 1000) begin
         @(negedge clock_i);
         c++;
      end
   endtask
   // dip the brown-out level, then report whether reset was seen high during or just after the dip
   task automatic dip(input int k, output logic hit);
      hit = 1'b0;
      sab = 1'b0;
      repeat (k) begin
         @(negedge clock_i);
         hit = hit | (chip_reset_o === 1'b1);
      end
      sab = 1'b1;
      repeat (3) begin
         @(negedge clock_i);
         hit = hit | (chip_reset_o === 1'b1);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_power_on();
      cyc(20);
      chk(chip_reset_o, 1'b1);
      sok = 1'b1;
      wait_rel(n);
      chk(n >= PT*RCP - RCP + OC*OSP - OSP && n <= PT*RCP + OC*OSP + 6, 1'b1);
      chk(power_on_flag_o, 1'b1);
      chk(non_power_up_reset_o, 1'b0);
      $display("test power_on done");
   endtask
   task automatic t_supply_loss();
      sok = 1'b0;
      cyc(3);
      chk(chip_reset_o, 1'b1);
      // a second power-on runs both timers again
      sok = 1'b1;
      wait_rel(n);
      chk(n >= PT*RCP - RCP + OC*OSP - OSP && n <= PT*RCP + OC*OSP + 6, 1'b1);
      chk(power_on_flag_o, 1'b1);
      sok = 1'b0;
      cyc(3);
      chk(chip_reset_o, 1'b1);
      put_off = 1'b1;
      mode = rss_pkg::OSC_RC;
      sok = 1'b1;
      wait_rel(n);
      chk(n <= 4, 1'b1);
      put_off = 1'b0;
      mode = rss_pkg::OSC_LOW_POWER;
      $display("test supply_loss done");
   endtask
   task automatic t_clear_wdt();
      clear_n = 1'b0;
      cyc(5);
      chk(chip_reset_o, 1'b1);
      clear_n = 1'b1;
      wait_rel(n);
      chk(n <= 3, 1'b1); // no timer on master clear
      chk(non_power_up_reset_o, 1'b1);
      chk(power_on_flag_o, 1'b0);
      cyc(2);
      wdt = 1'b1;
      cyc(1);
      chk(chip_reset_o, 1'b1);
      wdt = 1'b0;
      wait_rel(n);
      chk(n <= 3, 1'b1);
      chk(non_power_up_reset_o, 1'b1);
      $display("test clear_wdt done");
   endtask
   task automatic t_brownout();
      logic hit;
      // timer kept on while brown-out on
      bo_en = 1'b1;
      dip(1, hit);
      chk(hit, 1'b0);
      dip(BM, hit);
      chk(hit, 1'b0);
      dip(10, hit);
      chk(hit, 1'b1);
      cyc(30);
      chk(chip_reset_o, 1'b1);
      dip(10, hit);
      wait_rel(n);
      chk(n >= PT*RCP - RCP - 3 && n <= PT*RCP + OC*OSP + 6, 1'b1);
      chk(non_power_up_reset_o, 1'b1);
      bo_en = 1'b0;
      dip(20, hit);
      chk(hit, 1'b0);
      $display("test brownout done");
   endtask
   task automatic t_wake();
      // low-power crystal first, then high-speed crystal
      repeat (2) begin
         wake = 1'b1;
         cyc(1);
         wake = 1'b0;
         cyc(1);
         chk(chip_reset_o, 1'b1);
         wait_rel(n);
         chk(n >= OC*OSP - OSP - 1 && n <= OC*OSP + 4, 1'b1);
         mode = rss_pkg::OSC_HIGH_SPEED;
      end
      mode = rss_pkg::OSC_RC;
      wake = 1'b1;
      cyc(1);
      wake = 1'b0;
      cyc(3);
      chk(chip_reset_o, 1'b0);
      $display("test wake done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(16);
      rstn_i = 1'b1;
      t_power_on();
      t_supply_loss();
      t_clear_wdt();
      t_brownout();
      t_wake();
      stop_test();
   end
   initial begin
      cyc(5000);
      errors++;
      stop_test();
   end
endmodule
`default_nettype wire
